// ===== buck_fault_protection_sequencer.sv
// fault protection and mode sequencer for a synchronous step-down converter
// Operation
// - input overvoltage stops switching, drops power good
// - input overvoltage latches both switches off
// - undervoltage qualified 16us, then strap response
// - undervoltage recovery clears qualification counter
// - latch-off undervoltage: both off until re-enable
// - hiccup: stop, sleep 56ms, restart endlessly
// - output faults ignored until soft start done
// - overvoltage: high-side off, low-side on
// - negative limit: one on-time pulse, repeat
// - discharged: low-side latched on, high-side off
// - overvoltage hiccup: sleep timer from trip
// - power stage overtemperature: stop, restart when cool
// - controller overtemperature: strap fault response
// - power good low when disabled or rail low
// - power good after soft start plus 1ms
// - power good undriven while bias below 1.2V
// - forced continuous never cuts low-side on zero
// - skip mode cuts low-side on zero current
// - skip mode keeps on-time, period stretches
// - any enable and rail order powers up
// - straps captured once after reset, held
module buck_fault_protection_sequencer import buck_prot_pkg::*; #(
   parameter int HICCUP_CYC = HICCUP_CYCLES, // shorten in simulation
   parameter int PG_CYC = PG_CYCLES // shorten in simulation
) (
   // clock and reset (reset is the bias rail power-up)
   input wire logic ref_clk,
   input wire logic rst,
   // asynchronous comparator flags
   input wire logic power_input_rail_ov_flag,
   input wire logic power_input_rail_ok_flag,
   input wire logic fb_uv_flag,
   input wire logic fb_ov_flag,
   input wire logic ps_ot_flag,
   input wire logic ctrl_ot_flag,
   input wire logic zero_current_flag,
   input wire logic negative_current_limit,
   input wire logic output_discharged,
   input wire logic bias_ok,
   // pins and straps
   input wire logic turn_on_pin,
   input wire logic strap_skip_mode,
   input wire logic strap_hiccup,
   // same-clock loop control
   input wire logic high_side_request,
   input wire logic on_time_done,
   input wire logic soft_start_done,
   // switch commands
   output logic high_side_on,
   output logic low_side_on,
   output logic soft_start_run,
   // open-drain power good
   output logic power_good_out_o,
   output logic power_good_out_oe_n,
   // status
   output logic light_load_skip_mode,
   output logic hiccup_selected,
   output logic fault_latched
);
   // whole module state
   typedef struct packed {
      logic [SY_W-1:0] sy1; // first synchroniser stage
      logic [SY_W-1:0] sy2; // second synchroniser stage
      seq_state_type st; // sequencer state
      logic [1:0] strap_cnt; // wait before strap capture
      logic strap_valid; // straps captured
      logic skip; // captured mode: 1 = skip, 0 = forced continuous
      logic hic; // captured response: 1 = hiccup
      logic power_input_rail_latch; // latch caused by input overvoltage
      logic zc_off; // low-side cut by zero current this period
      logic [UV_CNT_W-1:0] uv_cnt; // undervoltage qualification
      logic [SLEEP_CNT_W-1:0] sleep_cnt; // hiccup sleep
      logic [PG_CNT_W-1:0] pg_cnt; // power good delay
      logic hs; // high-side command
      logic ls; // low-side command
      logic pg_good; // power good released
   } state_type;

   state_type s_r, s_nxt;

   // synchronised flags, readable names
   logic power_input_rail_ov, power_input_rail_ok, uv, ov, ps_ot, ctrl_ot, zc, neg_lim, en, bias, disch;
   logic uv_qual; // undervoltage delay expired
   logic sleep_done; // hiccup sleep expired
   logic guard_on; // output faults armed
   logic sleeping; // sleep counter running

   always_comb begin
      power_input_rail_ov = s_r.sy2[IX_POWER_INPUT_RAIL_OV];
      power_input_rail_ok = s_r.sy2[IX_POWER_INPUT_RAIL_OK];
      uv = s_r.sy2[IX_FB_UV];
      ov = s_r.sy2[IX_FB_OV];
      ps_ot = s_r.sy2[IX_PS_OT];
      ctrl_ot = s_r.sy2[IX_CTRL_OT];
      zc = s_r.sy2[IX_ZERO_CUR];
      neg_lim = s_r.sy2[IX_NEG_LIM];
      en = s_r.sy2[IX_ENABLE];
      bias = s_r.sy2[IX_BIAS_OK];
      disch = s_r.sy2[IX_DISCH];
   end

   // next-state logic
   always_comb begin
      s_nxt = s_r;
      // two-flop synchroniser on every asynchronous input
      s_nxt.sy1 = {strap_hiccup, strap_skip_mode, output_discharged, bias_ok, turn_on_pin,
         negative_current_limit, zero_current_flag, ctrl_ot_flag, ps_ot_flag, fb_ov_flag,
         fb_uv_flag, power_input_rail_ok_flag, power_input_rail_ov_flag};
      s_nxt.sy2 = s_r.sy1;

      // straps taken once the synchroniser has settled; turn-on pin never retakes
      if (!s_r.strap_valid) begin
         if (s_r.strap_cnt == STRAP_WAIT) begin
            s_nxt.strap_valid = 1'b1;
            s_nxt.skip = s_r.sy2[IX_STRAP_SKIP];
            s_nxt.hic = s_r.sy2[IX_STRAP_HIC];
         end else begin
            s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
         end
      end

      // output faults armed only after soft start
      guard_on = (s_r.st == ST_RUN) && soft_start_done;

      // undervoltage qualification: counts while low, zero on recovery
      uv_qual = guard_on && uv && (s_r.uv_cnt == UV_CNT_W'(UV_CYCLES - 1));
      if (guard_on && uv && !uv_qual) begin
         s_nxt.uv_cnt = s_r.uv_cnt + 1'b1;
      end else begin
         s_nxt.uv_cnt = '0;
      end

      // hiccup sleep counter, also runs from an overvoltage trip
      sleeping = (s_r.st == ST_SLEEP) ||
         (s_r.hic && (s_r.st inside {ST_OV_SINK, ST_OV_PULSE, ST_OV_HOLD}));
      sleep_done = sleeping && (s_r.sleep_cnt == SLEEP_CNT_W'(HICCUP_CYC - 1));
      s_nxt.sleep_cnt = sleeping ? s_r.sleep_cnt + 1'b1 : '0;

      // zero-current cut, only in skip mode; a new high-side request reopens it
      if (high_side_request) begin
         s_nxt.zc_off = 1'b0;
      end else if (s_r.skip && zc && s_r.ls) begin
         s_nxt.zc_off = 1'b1;
      end
      if (!s_r.skip) begin
         s_nxt.zc_off = 1'b0;
      end

      s_nxt.hs = 1'b0;
      s_nxt.ls = 1'b0;

      // sequencer
      unique case (s_r.st)
         ST_IDLE: begin
            // waits for both enable and rail in any order
            s_nxt.power_input_rail_latch = 1'b0;
            if (s_r.strap_valid && en && power_input_rail_ok && !power_input_rail_ov && !ps_ot) begin
               s_nxt.st = ST_RUN;
            end
         end
         ST_RUN: begin
            // regulation; the on-time comes unchanged from the loop in both modes
            s_nxt.hs = high_side_request;
            s_nxt.ls = !high_side_request && !s_nxt.zc_off;
            if (power_input_rail_ov) begin
               s_nxt.st = ST_LATCH_OFF;
               s_nxt.power_input_rail_latch = 1'b1;
               s_nxt.hs = 1'b0;
               s_nxt.ls = 1'b0;
            end else if (!en || !power_input_rail_ok) begin
               s_nxt.st = ST_IDLE;
               s_nxt.hs = 1'b0;
               s_nxt.ls = 1'b0;
            end else if (ctrl_ot || uv_qual) begin
               s_nxt.st = s_r.hic ? ST_SLEEP : ST_LATCH_OFF;
               s_nxt.hs = 1'b0;
               s_nxt.ls = 1'b0;
            end else if (ps_ot) begin
               s_nxt.st = ST_OT_WAIT;
               s_nxt.hs = 1'b0;
               s_nxt.ls = 1'b0;
            end else if (guard_on && ov) begin
               s_nxt.st = ST_OV_SINK;
               s_nxt.hs = 1'b0;
               s_nxt.ls = 1'b1;
            end
         end
         ST_OV_SINK: begin
            // low-side sinks until the negative limit
            s_nxt.ls = 1'b1;
            if (disch) begin
               s_nxt.st = ST_OV_HOLD;
            end else if (neg_lim) begin
               s_nxt.st = ST_OV_PULSE;
               s_nxt.hs = 1'b1;
               s_nxt.ls = 1'b0;
            end
         end
         ST_OV_PULSE: begin
            // one computed on-time of high-side
            s_nxt.hs = 1'b1;
            if (on_time_done) begin
               s_nxt.st = ST_OV_SINK;
               s_nxt.hs = 1'b0;
               s_nxt.ls = 1'b1;
            end
         end
         ST_OV_HOLD: begin
            s_nxt.ls = 1'b1;
         end
         ST_LATCH_OFF: begin
            // both off; enable low clears, rail drop clears an input latch too
            if (!en || (s_r.power_input_rail_latch && !power_input_rail_ok)) begin
               s_nxt.st = ST_IDLE;
            end
         end
         ST_SLEEP: begin
            if (!en) begin
               s_nxt.st = ST_IDLE;
            end
         end
         ST_OT_WAIT: begin
            // comparator hysteresis gives the 30 degree fall; never latches
            if (!ps_ot) begin
               s_nxt.st = ST_IDLE;
            end
         end
         default: begin
            s_nxt.st = ST_IDLE; // illegal code recovers to idle
         end
      endcase

      // common exits from the overvoltage states
      if (s_r.st inside {ST_OV_SINK, ST_OV_PULSE, ST_OV_HOLD}) begin
         if (power_input_rail_ov) begin
            s_nxt.st = ST_LATCH_OFF;
            s_nxt.power_input_rail_latch = 1'b1;
            s_nxt.hs = 1'b0;
            s_nxt.ls = 1'b0;
         end else if (!en || sleep_done) begin
            s_nxt.st = ST_IDLE;
            s_nxt.hs = 1'b0;
            s_nxt.ls = 1'b0;
         end
      end
      if (s_r.st == ST_SLEEP && sleep_done) begin
         s_nxt.st = ST_IDLE;
      end

      // power good delay counts from soft start completion
      if (guard_on) begin
         if (s_r.pg_cnt != PG_CNT_W'(PG_CYC)) begin
            s_nxt.pg_cnt = s_r.pg_cnt + 1'b1;
         end
      end else begin
         s_nxt.pg_cnt = '0;
      end
      s_nxt.pg_good = guard_on && (s_r.pg_cnt == PG_CNT_W'(PG_CYC)) && !uv && !ov &&
         en && power_input_rail_ok && !power_input_rail_ov && (s_nxt.st == ST_RUN);
   end

   // state register; constants only under reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_r <= '{sy1: '0, sy2: '0, st: ST_IDLE, strap_cnt: 2'h0, strap_valid: 1'b0,
            skip: 1'b0, hic: 1'b0, power_input_rail_latch: 1'b0, zc_off: 1'b0, uv_cnt: '0,
            sleep_cnt: '0, pg_cnt: '0, hs: 1'b0, ls: 1'b0, pg_good: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs; power good pulls low only when bias is valid and not good
   assign high_side_on = s_r.hs;
   assign low_side_on = s_r.ls;
   assign soft_start_run = (s_r.st == ST_RUN);
   assign power_good_out_o = 1'b0;
   assign power_good_out_oe_n = s_r.pg_good || !bias;
   assign light_load_skip_mode = s_r.skip;
   assign hiccup_selected = s_r.hic;
   assign fault_latched = (s_r.st == ST_LATCH_OFF) || (s_r.st == ST_OV_HOLD);

   // checks
   input_ov_off_a: assert property (@(posedge ref_clk) disable iff (rst)
      power_input_rail_ov && (s_r.st == ST_RUN) |=> !s_r.hs && !s_r.ls && !s_r.pg_good ##1
      !s_r.hs && !s_r.ls)
      else $error("switching continued after input overvoltage");
   input_latch_a: assert property (@(posedge ref_clk) disable iff (rst)
      (s_r.st == ST_LATCH_OFF) && en && power_input_rail_ok |=> (s_r.st == ST_LATCH_OFF))
      else $error("latch released without enable toggle");
   uv_qual_time_a: assert property (@(posedge ref_clk) disable iff (rst)
      (s_r.uv_cnt == UV_CNT_W'(UV_CYCLES - 1)) && uv && guard_on && !s_r.hic && en &&
      power_input_rail_ok && !power_input_rail_ov |=> (s_r.st == ST_LATCH_OFF))
      else $error("undervoltage response not taken at delay end");
   uv_cnt_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
      !uv |=> (s_r.uv_cnt == '0))
      else $error("qualification counter not cleared");
   uv_latch_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      (s_r.st == ST_LATCH_OFF) |-> !s_r.hs && !s_r.ls)
      else $error("switch on in latched state");
   sleep_restart_a: assert property (@(posedge ref_clk) disable iff (rst)
      (s_r.st == ST_SLEEP) && sleep_done |=> (s_r.st == ST_IDLE))
      else $error("hiccup did not restart");
   ss_guard_a: assert property (@(posedge ref_clk) disable iff (rst)
      (s_r.st == ST_RUN) && !soft_start_done && !power_input_rail_ov && en && power_input_rail_ok && !ctrl_ot &&
      !ps_ot |=> (s_r.st == ST_RUN))
      else $error("output fault acted on during soft start");
   ov_sink_a: assert property (@(posedge ref_clk) disable iff (rst)
      guard_on && ov && !uv_qual && !power_input_rail_ov && en && power_input_rail_ok && !ctrl_ot && !ps_ot
      |=> !s_r.hs && s_r.ls)
      else $error("overvoltage did not turn low-side on");
   ov_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
      (s_r.st == ST_OV_SINK) && neg_lim && !disch && !power_input_rail_ov && en && !sleep_done
      |=> s_r.hs && !s_r.ls)
      else $error("negative limit did not start on-time");
   ov_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      (s_r.st == ST_OV_HOLD) |-> !s_r.hs && s_r.ls)
      else $error("discharged state wrong switches");
   pg_delay_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(s_r.pg_good) |-> (s_r.pg_cnt == PG_CNT_W'(PG_CYC)) && $past(soft_start_done))
      else $error("power good before delay");
   pg_disable_a: assert property (@(posedge ref_clk) disable iff (rst)
      !en || !power_input_rail_ok |=> !s_r.pg_good)
      else $error("power good high while disabled");
   pg_hiz_a: assert property (@(posedge ref_clk) disable iff (rst)
      !bias |-> power_good_out_oe_n)
      else $error("power good driven without bias");
   forced_continuous_mode_ls_a: assert property (@(posedge ref_clk) disable iff (rst)
      (s_r.st == ST_RUN) && !s_r.skip && !high_side_request && en && power_input_rail_ok && !power_input_rail_ov &&
      !ctrl_ot && !ps_ot && !ov && !uv |=> s_r.ls)
      else $error("low-side cut in forced continuous mode");
   strap_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      s_r.strap_valid |=> $stable(s_r.skip) && $stable(s_r.hic))
      else $error("strap changed after capture");

   run_c: cover property (@(posedge ref_clk) disable iff (rst) $rose(s_r.pg_good));
   ov_cycle_c: cover property (@(posedge ref_clk) disable iff (rst)
      (s_r.st == ST_OV_PULSE) ##[1:50] (s_r.st == ST_OV_HOLD));
   hiccup_c: cover property (@(posedge ref_clk) disable iff (rst)
      (s_r.st == ST_SLEEP) ##1 (s_r.st == ST_IDLE));
   skip_cut_c: cover property (@(posedge ref_clk) disable iff (rst) s_r.zc_off);
endmodule

// ===== buck_fault_protection_sequencer_tb.sv
// self-checking bench for the buck fault protection sequencer
module buck_fault_protection_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import buck_prot_pkg::*;
   localparam int HIC = 200; // shortened hiccup sleep
   localparam int PGC = 50; // shortened power good delay
   // positions in the watched vector
   localparam int HS = 0, LS = 1, SSR = 2, OEN = 3, SKIP = 4, HIC_S = 5, FLT = 6, OFF = 7;
   localparam int SSD = 8, PGO = 9;
   typedef struct {int sel; logic val;} note_type;
   note_type exp_q[$]; // expected results, oldest first
   event sample_ev; // a note waits for comparison
   int errors = 0, n_compared = 0, seed = 68473;
   logic ref_clk = 0, rst = 1;
   logic power_input_rail_ov_flag = 0, power_input_rail_ok_flag = 0, fb_uv_flag = 0, fb_ov_flag = 0;
   logic ps_ot_flag = 0, ctrl_ot_flag = 0, bias_ok = 1, turn_on_pin = 0;
   logic strap_skip_mode = 1, strap_hiccup = 0, ov_event = 0, light_load = 0;
   logic zero_current_flag, negative_current_limit, output_discharged;
   logic high_side_request, on_time_done, soft_start_done;
   logic high_side_on, low_side_on, soft_start_run, power_good_out_o, power_good_out_oe_n;
   logic light_load_skip_mode, hiccup_selected, fault_latched;
   logic [9:0] outs; // watched outputs, plus both-off and ramp done
   assign outs = {power_good_out_o, soft_start_done, ~high_side_on & ~low_side_on,
      fault_latched, hiccup_selected, light_load_skip_mode, power_good_out_oe_n,
      soft_start_run, low_side_on, high_side_on};
   // 250 MHz reference clock
   always #2 ref_clk = ~ref_clk;
   buck_fault_protection_sequencer #(.HICCUP_CYC(HIC), .PG_CYC(PGC))
      u_buck_fault_protection_sequencer (.ref_clk, .rst, .power_input_rail_ov_flag, .power_input_rail_ok_flag,
      .fb_uv_flag, .fb_ov_flag, .ps_ot_flag, .ctrl_ot_flag, .zero_current_flag,
      .negative_current_limit, .output_discharged, .bias_ok, .turn_on_pin,
      .strap_skip_mode, .strap_hiccup, .high_side_request, .on_time_done,
      .soft_start_done, .high_side_on, .low_side_on, .soft_start_run, .power_good_out_o,
      .power_good_out_oe_n, .light_load_skip_mode, .hiccup_selected, .fault_latched);
   buck_stage_model u_buck_stage_model (.ref_clk, .rst, .high_side_on, .low_side_on,
      .soft_start_run, .ov_event, .light_load, .high_side_request, .on_time_done,
      .soft_start_done, .negative_current_limit, .output_discharged, .zero_current_flag);
   // wait a number of falling edges
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // note one expected output value
   task automatic expect_out(input int sel, input logic val);
      exp_q.push_back('{sel, val});
      -> sample_ev;
   endtask
   // bounded wait for an output level; a timeout shows up in the next compare
   task automatic wait_out(input int sel, input logic val, input int lim);
      int i;
      i = 0;
      while (outs[sel] !== val && i < lim) begin
         @(negedge ref_clk);
         i++;
      end
   endtask
   // compare one output bit
   task automatic cmp_bit(input logic exp, input logic act);
      n_compared++;
      if (act !== exp) begin
         errors++;
         $display("Error at %0t: expected %h got %h", $time, exp, act);
      end
   endtask
   // monitor drains every pending note against the outputs
   always @(sample_ev) begin
      note_type n;
      while (exp_q.size() > 0) begin
         n = exp_q.pop_front();
         cmp_bit(n.val, outs[n.sel]);
      end
   end
   // bias rail reset with strap levels
   task automatic do_reset(input logic skip, input logic hic);
      strap_skip_mode = skip;
      strap_hiccup = hic;
      rst = 1;
      cyc(5);
      expect_out(OFF, 1);
      expect_out(OEN, 1);
      rst = 0;
      cyc(10);
      expect_out(SKIP, skip);
      expect_out(HIC_S, hic);
   endtask
   // drop and raise the turn-on pin, then wait for the ramp
   task automatic toggle_en();
      turn_on_pin = 0;
      cyc(5);
      expect_out(OEN, 0);
      expect_out(PGO, 0);
      turn_on_pin = 1;
      wait_out(SSR, 1, 30);
      wait_out(SSD, 1, 60);
   endtask
   // verdict and end of run
   task automatic results();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog: the tests need about 15k cycles, allow twice that
   initial begin
      #120000;
      errors++;
      $display("watchdog expired");
      results();
   end
   // main sequence
   initial begin
      do_reset(1, 0);
      strap_skip_mode = 0; // later changes must not be taken
      strap_hiccup = 1;
      turn_on_pin = 1;
      cyc(10);
      power_input_rail_ok_flag = 1; // enable came before the rail
      wait_out(SSR, 1, 30);
      expect_out(SSR, 1);
      wait_out(SSD, 1, 60);
      cyc(PGC / 2);
      expect_out(OEN, 0);
      wait_out(OEN, 1, PGC + 20);
      expect_out(OEN, 1);
      light_load = 1;
      wait_out(OFF, 1, 60);
      expect_out(OFF, 1);
      light_load = 0;
      $display("test startup and skip mode done");
      fb_uv_flag = 1;
      cyc(1000 + $unsigned($random(seed)) % 2000);
      fb_uv_flag = 0;
      cyc(10);
      expect_out(FLT, 0);
      fb_uv_flag = 1;
      cyc(3900);
      expect_out(FLT, 0);
      wait_out(FLT, 1, 200);
      expect_out(FLT, 1);
      expect_out(OFF, 1);
      fb_uv_flag = 0;
      cyc(20);
      expect_out(FLT, 1);
      toggle_en();
      expect_out(SSR, 1);
      expect_out(SKIP, 1);
      $display("test undervoltage latch done");
      fb_ov_flag = 1;
      ov_event = 1;
      cyc(5);
      expect_out(HS, 0);
      expect_out(LS, 1);
      wait_out(HS, 1, 30);
      expect_out(HS, 1);
      expect_out(LS, 0);
      wait_out(FLT, 1, 200);
      expect_out(HS, 0);
      expect_out(LS, 1);
      fb_ov_flag = 0;
      ov_event = 0;
      cyc(20);
      expect_out(FLT, 1);
      toggle_en();
      $display("test overvoltage latch done");
      wait_out(OEN, 1, PGC + 20);
      expect_out(OEN, 1);
      power_input_rail_ov_flag = 1;
      cyc(5);
      expect_out(OFF, 1);
      expect_out(OEN, 0);
      power_input_rail_ov_flag = 0;
      cyc(10);
      expect_out(OFF, 1);
      power_input_rail_ok_flag = 0;
      cyc(5);
      power_input_rail_ok_flag = 1;
      wait_out(SSR, 1, 30);
      expect_out(SSR, 1);
      ps_ot_flag = 1;
      cyc(5);
      expect_out(SSR, 0);
      expect_out(OFF, 1);
      cyc(20 + $unsigned($random(seed)) % 50);
      ps_ot_flag = 0;
      wait_out(SSR, 1, 20);
      expect_out(SSR, 1);
      bias_ok = 0;
      cyc(5);
      expect_out(OEN, 1);
      bias_ok = 1;
      cyc(5);
      wait_out(OEN, 1, PGC + 60);
      expect_out(OEN, 1);
      turn_on_pin = 0;
      cyc(5);
      expect_out(OEN, 0);
      $display("test input overvoltage and temperature done");
      turn_on_pin = 0;
      do_reset(0, 1);
      turn_on_pin = 1; // rail came before enable
      wait_out(SSR, 1, 30);
      expect_out(SSR, 1);
      wait_out(SSD, 1, 60);
      light_load = 1;
      wait_out(OFF, 1, 60);
      expect_out(OFF, 0);
      light_load = 0;
      fb_uv_flag = 1;
      wait_out(SSR, 0, 4100);
      fb_uv_flag = 0;
      expect_out(FLT, 0);
      expect_out(OFF, 1);
      cyc(HIC - 60);
      expect_out(SSR, 0);
      wait_out(SSR, 1, 90);
      expect_out(SSR, 1);
      ctrl_ot_flag = 1;
      cyc(5);
      expect_out(SSR, 0);
      ctrl_ot_flag = 0;
      cyc(HIC - 60);
      expect_out(SSR, 0);
      wait_out(SSR, 1, 90);
      expect_out(SSR, 1);
      wait_out(SSD, 1, 60);
      fb_ov_flag = 1;
      ov_event = 1;
      cyc(5);
      expect_out(LS, 1);
      cyc(HIC - 60);
      expect_out(SSR, 0);
      wait_out(SSR, 1, 90);
      expect_out(SSR, 1);
      cyc(10);
      expect_out(SSR, 1);
      fb_ov_flag = 0;
      ov_event = 0;
      $display("test hiccup responses done");
      cyc(2);
      results();
   end
endmodule

// ===== buck_prot_pkg.sv
// shared constants and types for the buck fault protection sequencer
package buck_prot_pkg;
   // reference clock
   localparam int CLK_MHZ = 250; // clock rate in MHz
   // undervoltage qualification delay
   localparam int UV_DELAY_NS = 16000; // 16 us
   localparam int UV_CYCLES = UV_DELAY_NS * CLK_MHZ / 1000; // 4000 cycles, least time
   localparam int UV_CNT_W = 12;
   // hiccup sleep time
   localparam int HICCUP_MS = 56;
   localparam int HICCUP_CYCLES = HICCUP_MS * CLK_MHZ * 1000; // 14,000,000 cycles
   localparam int SLEEP_CNT_W = 24;
   // power good delay after soft start
   localparam int PG_DELAY_MS = 1;
   localparam int PG_CYCLES = PG_DELAY_MS * CLK_MHZ * 1000; // 250,000 cycles
   localparam int PG_CNT_W = 18;
   // strap capture wait after reset release, in cycles
   localparam logic [1:0] STRAP_WAIT = 2'h3;
   // positions in the synchronised flag vector
   localparam int SY_W = 13;
   localparam int IX_POWER_INPUT_RAIL_OV = 0; // power_input_rail above overvoltage trip
   localparam int IX_POWER_INPUT_RAIL_OK = 1; // power_input_rail sufficient
   localparam int IX_FB_UV = 2; // feedback_node at or below 400 mV
   localparam int IX_FB_OV = 3; // feedback_node at or above 750 mV
   localparam int IX_PS_OT = 4; // power stage overtemperature
   localparam int IX_CTRL_OT = 5; // controller overtemperature
   localparam int IX_ZERO_CUR = 6; // zero inductor current detected
   localparam int IX_NEG_LIM = 7; // negative_current_limit reached
   localparam int IX_ENABLE = 8; // turn-on pin
   localparam int IX_BIAS_OK = 9; // bias rail above 1.2 V
   localparam int IX_DISCH = 10; // output fully discharged
   localparam int IX_STRAP_SKIP = 11; // strap: light_load_skip_mode
   localparam int IX_STRAP_HIC = 12; // strap: hiccup response
   // sequencer states, one-hot
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01, // waiting for enable and input rail
      ST_RUN = 8'h02, // soft start and regulation
      ST_OV_SINK = 8'h04, // low-side on, sinking toward the negative limit
      ST_OV_PULSE = 8'h08, // high-side on for one on-time
      ST_OV_HOLD = 8'h10, // discharged: high-side off, low-side on
      ST_LATCH_OFF = 8'h20, // both switches off until re-enable, or until the rail drops after an input overvoltage
      ST_SLEEP = 8'h40, // hiccup sleep
      ST_OT_WAIT = 8'h80 // power stage too hot, waiting to cool
   } seq_state_type;
endpackage

// ===== buck_stage_model.sv
// power stage, loop and output comparator model facing the sequencer
module buck_stage_model #(
   parameter int ON_CYC = 6, // on-time length in cycles
   parameter int SS_CYC = 20, // soft start ramp length
   parameter int SINK_CYC = 8, // sinking time before the negative limit trips
   parameter int PULSES = 3 // on-time pulses until the output is empty
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // switch commands seen by the stage
   input wire logic high_side_on,
   input wire logic low_side_on,
   input wire logic soft_start_run,
   // scenario controls from the bench
   input wire logic ov_event,
   input wire logic light_load,
   // loop and comparator outputs
   output logic high_side_request,
   output logic on_time_done,
   output logic soft_start_done,
   output logic negative_current_limit,
   output logic output_discharged,
   output logic zero_current_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   int ss_cnt, hs_cnt, ls_cnt, sk_cnt, per_cnt, pulses; // stage counters
   logic ov_q, ll_q; // bench controls, retimed
   // bench controls change on the falling edge; take them on the rising one so
   // the falling-edge stage process never races the bench's own drive
   always @(posedge ref_clk) begin
      ov_q <= ov_event;
      ll_q <= light_load;
   end
   // all stage outputs move on the falling edge, like the bench's drive
   always @(negedge ref_clk or posedge rst) begin
      if (rst) begin
         {ss_cnt, hs_cnt, ls_cnt, sk_cnt, per_cnt, pulses} <= '0;
         {high_side_request, on_time_done, soft_start_done} <= 3'h0;
         {negative_current_limit, output_discharged, zero_current_flag} <= 3'h0;
      end else begin
         // ramp restarts whenever the sequencer leaves run
         ss_cnt <= soft_start_run ? ss_cnt + 1 : 0;
         soft_start_done <= soft_start_run && ss_cnt >= SS_CYC;
         hs_cnt <= high_side_on ? hs_cnt + 1 : 0;
         on_time_done <= high_side_on && hs_cnt >= ON_CYC - 1;
         ls_cnt <= low_side_on ? ls_cnt + 1 : 0;
         // loop asks for one on-time in every four
         per_cnt <= (per_cnt == 4 * ON_CYC - 1) ? 0 : per_cnt + 1;
         high_side_request <= soft_start_run && !ov_q && per_cnt < ON_CYC;
         // sinking only counts during an overvoltage, so the first trip is never early
         sk_cnt <= (ov_q && low_side_on) ? sk_cnt + 1 : 0;
         negative_current_limit <= ov_q && low_side_on && sk_cnt >= SINK_CYC;
         if (!ov_q)
            pulses <= 0;
         else if (high_side_on && hs_cnt == 0)
            pulses <= pulses + 1;
         output_discharged <= ov_q && pulses >= PULSES;
         // current reaches zero a little after the low side turns on at light load
         zero_current_flag <= ll_q && low_side_on && ls_cnt >= 3;
      end
   end
endmodule
